// file: design/swcl_loader.sv
// Serial wiper code loader: 3-wire serial input, four wiper code latches, chain output.
// Assumes all serial pins are asynchronous to clock, which must run at least twice the shift clock.
//
// Notes on behaviour
// - Word is two address bits then eight data bits, most significant first.
// - Channel number is twice high address bit plus low address bit plus one.
// - Each channel updates alone; other latches stay unchanged.
// - Shift clock up to 10 MHz is accepted.
// - Latches have no defined power-up value; system reset leaves them alone.
// - Midscale reset low forces every latch to 128.
// - Shutdown opens high terminals and ties wipers to low terminals.
// - Shutdown keeps latches; release resumes retained positions.
// - Shifting and loading work in shutdown; chain output reads high.
// - Codes loaded in shutdown take effect when shutdown ends.
// - Each latch decodes to a one-of-256 tap; code 00 is nearest low end.
// - Each code step moves one tap higher; 255 is full scale.
// - With select low, each rising shift clock edge shifts in one bit.
// - On select rising, the last ten bits are decoded and loaded if they address an implemented channel.
// - Chain output gives the bit shifted in ten edges earlier.
// - Midscale reset low holds latches at midscale and clears chain latch.
`timescale 1ns/1ps
`default_nettype none
module swcl_loader (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Variant strap: number of implemented channels, 1, 2 or 4
  input wire logic [2:0] channel_count,
  // Serial pins
  input wire logic shift_clock_pin,
  input wire logic chip_select_n,
  input wire logic serial_input_pin,
  input wire logic midscale_reset_n,
  input wire logic power_down_n,
  // Open-drain chain output: enable low pulls the pin low
  output logic chain_output_pin,
  output logic chain_output_oe_n,
  // Analog switch controls per channel
  output logic [3:0][7:0] wiper_code_latch,
  output logic [3:0][255:0] tap_select,
  output swcl_pkg::swcl_switch_t [3:0] switch_control
);
  logic [1:0] sck_sync;
  logic [1:0] cs_sync;
  logic [1:0] sdi_sync;
  logic [1:0] rs_sync;
  logic [1:0] pd_sync;
  logic sck_last;
  logic cs_last;
  logic [9:0] shift_reg;
  logic chain_latch;
  logic [3:0][7:0] code_latch;
  logic [3:0][255:0] tap_reg;
  logic [3:0] switch_high_open;
  logic [2:0] channels;
  swcl_pkg::swcl_state_t state;
  swcl_pkg::swcl_state_t next_state;

  // Synchronisers: the second stage alone feeds logic.
  // Reset values match each pin's idle level, so no false edge follows reset.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_sync <= swcl_pkg::SYNC_RESET;
      cs_sync <= 2'h3;
      sdi_sync <= swcl_pkg::SYNC_RESET;
      rs_sync <= 2'h3;
      pd_sync <= 2'h3;
    end else begin
      sck_sync <= {sck_sync[0], shift_clock_pin};
      cs_sync <= {cs_sync[0], chip_select_n};
      sdi_sync <= {sdi_sync[0], serial_input_pin};
      rs_sync <= {rs_sync[0], midscale_reset_n};
      pd_sync <= {pd_sync[0], power_down_n};
    end
  end

  wire sck_s = sck_sync[1];
  wire cs_s = cs_sync[1];
  wire sdi_s = sdi_sync[1];
  wire rs_s = rs_sync[1];
  wire pd_s = pd_sync[1];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_last <= 1'b0;
      cs_last <= 1'b1;
    end else begin
      sck_last <= sck_s;
      cs_last <= cs_s;
    end
  end

  // Strap is sampled only between frames with select high, so a change never splits a word.
  // A strap that moves mid-frame takes effect at the next idle period.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channels <= swcl_pkg::CHANNEL_COUNT_DEFAULT;
    end else if (state == swcl_pkg::SWCL_IDLE && cs_s) begin
      channels <= channel_count;
    end
  end

  // Edges are found on the synchronised copies, so each one is seen a few clocks late.
  wire sck_rise = sck_s & ~sck_last;
  wire shift_now = sck_rise & ~cs_s;
  wire cs_rise = cs_s & ~cs_last;
  wire in_reset = ~rs_s;
  wire in_shutdown = ~pd_s;

  // One-hot latch enables from the two address bits.
  function automatic logic [3:0] latch_enables(input logic [1:0] address);
    latch_enables = 4'h1 << address;
  endfunction : latch_enables

  // Shift register is a word in order: address bits first, then code bits.
  swcl_pkg::swcl_word_t word;
  assign word = shift_reg;
  wire [2:0] channel_number = {1'b0, word.address} + 3'h1;
  wire address_ok = channel_number <= channels;
  wire load_now = (state == swcl_pkg::SWCL_LOAD) && address_ok;
  // A missing channel fails address_ok, so no latch is written at all.
  wire [3:0] load_select = latch_enables(word.address);

  // A frame walks idle, shift, then one load cycle once select has risen.
  always_comb begin
    next_state = state;
    case (state)
      swcl_pkg::SWCL_IDLE: if (!cs_s) next_state = swcl_pkg::SWCL_SHIFT;
      swcl_pkg::SWCL_SHIFT: if (cs_rise) next_state = swcl_pkg::SWCL_LOAD;
      swcl_pkg::SWCL_LOAD: next_state = swcl_pkg::SWCL_IDLE;
      default: next_state = swcl_pkg::SWCL_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst || in_reset) begin
      state <= swcl_pkg::SWCL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Shifting goes on in shutdown; the shift register is untouched by reset pins.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shift_reg <= swcl_pkg::SHIFT_RESET;
    end else if (shift_now) begin
      shift_reg <= {shift_reg[8:0], sdi_s};
    end
  end

  // The bit leaving the top is the one entered ten edges ago.
  always_ff @(posedge clock) begin
    if (sys_rst || in_reset) begin
      chain_latch <= 1'b0;
    end else if (shift_now) begin
      chain_latch <= shift_reg[9];
    end
  end

  // Latches are deliberately outside sys_rst so power-up contents stay arbitrary.
  // One process writes all four latches, so the packed array has a single driver.
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (in_reset) begin
        code_latch[i] <= swcl_pkg::MIDSCALE_CODE;
      end else if (load_now && load_select[i]) begin
        code_latch[i] <= word.code;
      end
    end
  end

  // Each channel has its own decoder so all four taps move in the same cycle.
  wire logic [3:0][255:0] tap_next;
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      swcl_tap_decoder u_dec (
        .code(code_latch[ch]),
        .tap_select(tap_next[ch])
      );
    end
  endgenerate

  // Registering the decode keeps the tap outputs free of glitches while a latch changes.
  always_ff @(posedge clock) begin
    tap_reg <= tap_next;
  end

  // Shutdown steers switches and releases the chain pin; codes stay, so release restores positions.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      switch_high_open <= 4'hF;
    end else begin
      switch_high_open <= {4{in_shutdown}};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chain_output_pin <= 1'b1;
      chain_output_oe_n <= 1'b1;
    end else begin
      // The pin only ever pulls low; a pull-up outside gives the high level.
      chain_output_pin <= 1'b0;
      // Pin released in shutdown to stop pull-up dissipation, and while select is high.
      chain_output_oe_n <= in_shutdown | cs_s | chain_latch;
    end
  end

  assign wiper_code_latch = code_latch;
  assign tap_select = tap_reg;
  // Both switch controls of a channel move together, so there is no half-off state.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      switch_control[i].high_open = switch_high_open[i];
      switch_control[i].wiper_to_low = switch_high_open[i];
    end
  end
endmodule : swcl_loader
`default_nettype wire

// file: design/swcl_pkg.sv
// Package for the serial wiper code loader: widths, reset values and carrier types.
// Assumes nothing of its surroundings; every user names items as swcl_pkg::name.
package swcl_pkg;
  localparam int WORD_BITS = 10;
  localparam int CODE_BITS = 8;
  localparam int ADDR_BITS = 2;
  localparam int CHANNELS = 4;
  localparam int TAPS = 256;
  localparam int ADDR_POS = 8;
  localparam int DATA_POS = 0;
  localparam logic [7:0] MIDSCALE_CODE = 8'h80;
  localparam logic [9:0] SHIFT_RESET = 10'h000;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [2:0] CHANNEL_COUNT_DEFAULT = 3'h4;
  // The serial clock may reach 10 MHz; the sampling clock must be at least twice that.
  localparam int SHIFT_CLOCK_MAX_KHZ = 10000;
  localparam int SHIFT_PERIOD_MIN_NS = 100;

  typedef struct packed {
    logic [1:0] address;
    logic [7:0] code;
  } swcl_word_t;

  typedef struct packed {
    logic high_open;
    logic wiper_to_low;
  } swcl_switch_t;

  typedef enum logic [1:0] {
    SWCL_IDLE = 2'b00,
    SWCL_SHIFT = 2'b01,
    SWCL_LOAD = 2'b11
  } swcl_state_t;
endpackage : swcl_pkg

// file: design/swcl_tap_decoder.sv
// Tap decoder: turns one 8-bit wiper code into a one-of-256 tap select.
// Assumes a code from a latch on the same clock; output is combinational.
`timescale 1ns/1ps
`default_nettype none
module swcl_tap_decoder (
  // Code in
  input wire logic [7:0] code,
  // Tap select out, bit 0 nearest the low end terminal
  output logic [255:0] tap_select
);
  // Each step of the code moves the selected tap one place toward the high end.
  assign tap_select = 256'h1 << code;
endmodule : swcl_tap_decoder
`default_nettype wire

// file: testbench/swcl_loader_asserts.sv
// Checker: timing relations at the loader's ports.
// Bound from tb_top; sees only the loader's ports.
`timescale 1ns/1ps
`default_nettype none
module swcl_loader_asserts (
  // Watched ports
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic midscale_reset_n,
  input wire logic power_down_n,
  input wire logic chain_output_oe_n,
  input wire logic [3:0][7:0] wiper_code_latch,
  input wire logic [3:0][255:0] tap_select,
  input wire swcl_pkg::swcl_switch_t [3:0] switch_control
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_idle;
    chip_select_n && midscale_reset_n;
  endsequence
  // Select low while midscale reset holds the chain latch cleared.
  sequence s_cleared;
    !midscale_reset_n && !chip_select_n && power_down_n;
  endsequence
  AST_POWER_DOWN_N_SW: assert property (!power_down_n [*4] |-> switch_control == 8'hFF)
    else $error("switches not off");
  AST_RUN_SW: assert property (power_down_n [*4] |-> switch_control == 8'h00)
    else $error("switches stuck off");
  AST_HOLD: assert property (s_idle [*8] |=> $stable(wiper_code_latch))
    else $error("latch moved unloaded");
  AST_MID: assert property (!midscale_reset_n [*4] |=> wiper_code_latch == {4{8'h80}})
    else $error("latch not midscale");
  AST_SDO_OFF: assert property (!power_down_n [*4] |-> chain_output_oe_n)
    else $error("chain on in shutdown");
  AST_SEL_OFF: assert property (s_idle [*4] |-> chain_output_oe_n)
    else $error("chain on while idle");
  AST_CHAIN_CLR: assert property (s_cleared [*4] |=> !chain_output_oe_n)
    else $error("chain latch not cleared");
  AST_LOAD: assert property ($changed(wiper_code_latch) && $past(midscale_reset_n, 4) && midscale_reset_n
    |-> $past(chip_select_n, 3)) else $error("load not after select");
  for (genvar c = 0; c < 4; c++) begin : g_tap
    AST_TAP: assert property (midscale_reset_n |-> tap_select[c] == (256'h1 << $past(wiper_code_latch[c])))
      else $error("tap mismatch");
  end
endmodule : swcl_loader_asserts
`default_nettype wire

// file: testbench/swcl_host.sv
// Host model: serial master sending 20-bit frames at a 400 ns shift clock.
// Assumes the caller starts each frame just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module swcl_host (
  // System clock
  input wire logic clock,
  // Serial pins
  output logic shift_clock_pin,
  output logic chip_select_n,
  output logic serial_input_pin,
  // Chain pin level and the bits it gave back
  input wire logic chain_level,
  output logic [9:0] seen
);
  initial begin
    shift_clock_pin = 1'b0;
    chip_select_n = 1'b1;
    serial_input_pin = 1'b0;
    seen = 10'h000;
  end
  // The first ten bits must reappear on the chain pin while the last ten are shifted.
  task automatic send(input logic [19:0] b);
    chip_select_n <= 1'b0;
    for (int i = 19; i >= 0; i--) begin
      serial_input_pin <= b[i];
      repeat (4) @(posedge clock);
      if (i < 9) seen[i + 1] <= chain_level;
      shift_clock_pin <= 1'b1;
      repeat (4) @(posedge clock);
      shift_clock_pin <= 1'b0;
    end
    repeat (4) @(posedge clock);
    seen[0] <= chain_level;
    chip_select_n <= 1'b1;
    serial_input_pin <= ~b[0];
    repeat (4) @(posedge clock);
  endtask : send
endmodule : swcl_host
`default_nettype wire

// file: testbench/tb_top.sv
// Top bench: loader, host model and bound checker, one task per scenario.
// Assumes the package, loader, checker and host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] channel_count = 3'h4;
  logic midscale_reset_n = 1'b0;
  logic power_down_n = 1'b1;
  wire logic shift_clock_pin, chip_select_n, serial_input_pin, chain_output_pin, chain_output_oe_n;
  wire logic [9:0] seen;
  wire logic [3:0][7:0] wiper_code_latch;
  wire logic [3:0][255:0] tap_select;
  wire swcl_pkg::swcl_switch_t [3:0] switch_control;
  int err_count = 0;
  int comparisons = 0;
  swcl_loader swcl_loader_i (.clock, .sys_rst, .channel_count, .shift_clock_pin, .chip_select_n,
    .serial_input_pin, .midscale_reset_n, .power_down_n, .chain_output_pin, .chain_output_oe_n,
    .wiper_code_latch, .tap_select, .switch_control);
  swcl_host swcl_host_i (.clock, .shift_clock_pin, .chip_select_n, .serial_input_pin,
    .chain_level(chain_output_oe_n ? 1'b1 : chain_output_pin), .seen);
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_tap(input int c, input logic [7:0] code);
    comparisons++;
    if (tap_select[c] !== (256'h1 << code)) begin
      err_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, tap_select[c], 256'h1 << code);
    end
  endtask : chk_tap
  task automatic give_verdict();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic put(input logic [9:0] w, input logic [9:0] ce);
    swcl_host_i.send({10'h2A5, w});
    repeat (8) @(posedge clock);
    chk(32'(seen), 32'(ce));
  endtask : put
  task automatic t_load();
    put(10'h3FF, 10'h2A5);
    put(10'h000, 10'h2A5);
    put(10'h201, 10'h2A5);
    put(10'h17F, 10'h2A5);
    chk(wiper_code_latch, 32'hFF017F00);
    chk_tap(3, 8'hFF);
    chk_tap(0, 8'h00);
  endtask : t_load
  task automatic t_refuse();
    channel_count <= 3'h2;
    @(posedge clock);
    put(10'h255, 10'h2A5);
    put(10'h1AA, 10'h2A5);
    chk(wiper_code_latch, 32'hFF01AA00);
    channel_count <= 3'h4;
  endtask : t_refuse
  task automatic t_power_down_n();
    power_down_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk(32'(switch_control), 32'hFF);
    put(10'h03C, 10'h3FF);
    chk(wiper_code_latch, 32'hFF01AA3C);
    power_down_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk(32'(switch_control), 32'h00);
    chk_tap(0, 8'h3C);
  endtask : t_power_down_n
  // A frame sent while midscale reset is low must load nothing and leave the chain latch cleared.
  task automatic t_mid();
    midscale_reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk(wiper_code_latch, {4{8'h80}});
    put(10'h0FF, 10'h000);
    chk(wiper_code_latch, {4{8'h80}});
    midscale_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    put(10'h0C3, 10'h2A5);
    chk(wiper_code_latch, 32'h808080C3);
    chk_tap(0, 8'hC3);
  endtask : t_mid
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    midscale_reset_n <= 1'b1;
    chk(wiper_code_latch, {4{8'h80}});
    t_load();
    t_refuse();
    t_power_down_n();
    t_mid();
    give_verdict();
  end
  // A frame takes about 170 cycles, so this ceiling only trips on a hang.
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    give_verdict();
  end
endmodule : tb_top
bind swcl_loader swcl_loader_asserts swcl_loader_asserts_i (.clock, .sys_rst, .chip_select_n,
  .midscale_reset_n, .power_down_n, .chain_output_oe_n, .wiper_code_latch, .tap_select, .switch_control);
`default_nettype wire
